//--- test/mbh_checker.sv
// port checker for the write and loop-back handler
// assumes it is bound to mbh_handler and sees only its ports
`timescale 1ns/1ns
`default_nettype none

module mbh_checker
  import mbh_pkg::*;
(
  input wire logic       core_clk,     // system clock
  input wire logic       sys_rst,      // async reset, high
  input wire logic [7:0] station_addr, // own station address
  input wire mbh_rx_type rx,           // received bytes
  input wire logic       tx_ready,     // reply sink ready
  input wire mbh_tx_type tx,           // reply bytes
  input wire mbh_wr_type wr,           // register writes
  input wire logic       busy          // query in progress
);
  logic       start_reg;
  logic [7:0] addr_reg;
  logic       err_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // ------------------------------------------------------------
  // frame tracking
  // ------------------------------------------------------------
  // a byte after a frame end opens the next frame
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      start_reg <= 1'b1;
    else if (rx.valid && !busy)
      start_reg <= rx.last;
  end

  // station byte and sticky byte error of the current frame
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      addr_reg <= 8'h00;
      err_reg  <= 1'b0;
    end
    else if (rx.valid && !busy)
    begin
      if (start_reg)
        addr_reg <= rx.data;
      err_reg <= rx.err || (err_reg && !start_reg);
    end
  end

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_tx_hold;
    tx.valid && !tx_ready |=> tx.valid && $stable(tx.data);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("reply byte dropped before taken");

  property p_tx_in_busy;
    tx.valid |-> busy;
  endproperty
  a_tx_in_busy: assert property (p_tx_in_busy)
    else $error("reply byte outside a query");

  property p_end_busy;
    rx.valid && rx.last && !busy |=> busy;
  endproperty
  a_end_busy: assert property (p_end_busy)
    else $error("frame end not taken up");

  property p_bcast_quiet;
    busy && addr_reg == BCAST_ADDR |-> !tx.valid;
  endproperty
  a_bcast_quiet: assert property (p_bcast_quiet)
    else $error("reply sent to broadcast");

  property p_foreign_quiet;
    busy && addr_reg != BCAST_ADDR && addr_reg != station_addr
      |-> !tx.valid && !wr.en;
  endproperty
  a_foreign_quiet: assert property (p_foreign_quiet)
    else $error("foreign station query acted on");

  property p_err_quiet;
    busy && err_reg |-> !tx.valid && !wr.en;
  endproperty
  a_err_quiet: assert property (p_err_quiet)
    else $error("errored query acted on");

  property p_wr_ascend;
    wr.en && $past(wr.en) |-> wr.addr == $past(wr.addr) + 16'h0001;
  endproperty
  a_wr_ascend: assert property (p_wr_ascend)
    else $error("write addresses not ascending");

  property p_reply_start;
    $fell(wr.en) && addr_reg != BCAST_ADDR |=> tx.valid;
  endproperty
  a_reply_start: assert property (p_reply_start)
    else $error("reply late after writes");

  c_reply: cover property (tx.valid && tx_ready);
  c_stall: cover property (tx.valid && !tx_ready);
  c_bcast_wr: cover property (wr.en && addr_reg == BCAST_ADDR);
endmodule

bind mbh_handler mbh_checker mbh_checker_inst (
  .core_clk(core_clk), .sys_rst(sys_rst), .station_addr(station_addr),
  .rx(rx), .tx_ready(tx_ready), .tx(tx), .wr(wr), .busy(busy)
);

`default_nettype wire

//--- test/mbh_master_model.sv
// serial link master: sends query frames and sinks the replies
// assumes byte framing is already stripped; slow stalls the sink
`timescale 1ns/1ns
`default_nettype none

module mbh_master_model
  import mbh_pkg::*;
(
  input  wire logic core_clk, // system clock
  input  wire logic busy,     // handler still processing
  output mbh_rx_type rx,      // query byte stream
  output logic       tx_ready // reply sink ready
);
  logic       slow = 1'b0;
  logic [1:0] cnt  = 2'h0;

  initial rx = '0;
  initial tx_ready = 1'b1;

  // slow sink takes one byte in four to stretch replies
  always @(posedge core_clk)
  begin
    cnt <= cnt + 2'h1;
    tx_ready <= #1 (!slow || cnt == 2'h0);
  end

  // bytes back to back; e marks the byte carrying a line error
  task automatic send(input logic [7:0] b[$], input int e);
    foreach (b[i])
    begin
      @(posedge core_clk);
      #1 rx = '{1'b1, i == b.size() - 1, i == e, b[i]};
    end
    @(posedge core_clk);
    #1 rx = '{1'b0, 1'b0, 1'b0, ~b[b.size() - 1]};
    @(posedge core_clk);
    #1;
    // no reply marks a broadcast, so wait out busy first; a stuck busy
    // is left to the bench's cycle ceiling, which counts it as a failure
    while (busy)
    begin
      @(posedge core_clk);
      #1;
    end
  endtask
endmodule

`default_nettype wire

//--- test/tb.sv
// self-checking bench for the write and loop-back handler
// assumes the master model drives queries and sinks replies
`timescale 1ns/1ns
`default_nettype none

module tb;
  import mbh_pkg::*;
  logic        core_clk     = 1'b0;
  logic        sys_rst      = 1'b1;
  logic [7:0]  station_addr = 8'h05;
  mbh_rx_type  rx;
  logic        tx_ready;
  mbh_tx_type  tx;
  mbh_wr_type  wr;
  logic        busy;
  int          fails  = 0;
  int          checks = 0;
  int          cycles = 0;
  int          seed   = 71773;
  logic [7:0]  f[$];
  logic [7:0]  tq[$];
  logic [31:0] wq[$];
  logic [15:0] rc;

  always #2 core_clk = ~core_clk;

  mbh_handler mbh_handler_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .station_addr(station_addr),
    .rx(rx), .tx_ready(tx_ready), .tx(tx), .wr(wr), .busy(busy)
  );
  mbh_master_model mbh_master_model_inst (
    .core_clk(core_clk), .busy(busy), .rx(rx), .tx_ready(tx_ready)
  );

  task automatic chk(input string n, input logic [31:0] s, e);
    checks++;
    if (s !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // reflected crc, low byte goes out first
  function automatic logic [15:0] crc(input logic [7:0] b[$]);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (b[i])
    begin
      c ^= {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return c;
  endfunction

  task automatic seal;
    logic [15:0] c;
    c = crc(f);
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
  endtask

  task automatic single(input logic [7:0] a, input logic [15:0] r, d);
    f = {a, FC_WRITE_ONE, r[15:8], r[7:0], d[15:8], d[7:0]};
    seal();
    // only the two writable windows take the value; the echo still goes out
    if (r <= SYS_HI || (r >= PAR_LO && r <= PAR_HI))
      wq.push_back({r, d});
    if (a != BCAST_ADDR)
      tq = f;
    mbh_master_model_inst.send(f, -1);
  endtask

  task automatic loopback(input logic [15:0] d);
    f = {station_addr, FC_DIAG, 8'h00, 8'h00, d[15:8], d[7:0]};
    seal();
    tq = f;
    mbh_master_model_inst.send(f, -1);
  endtask

  task automatic many(input logic [7:0] a, input logic [15:0] s,
                      input logic [15:0] w[$]);
    f = {a, FC_WRITE_MANY, s[15:8], s[7:0], 8'h00, 8'(w.size()),
         8'(2 * w.size())};
    foreach (w[i])
    begin
      f.push_back(w[i][15:8]);
      f.push_back(w[i][7:0]);
      wq.push_back({s + 16'(i), w[i]});
    end
    seal();
    tq = f[0:5];
    rc = crc(tq);
    rc = {rc[7:0], rc[15:8]};
    if (a != BCAST_ADDR)
      tq = {tq, rc[15:8], rc[7:0]};
    else
      tq = {};
    mbh_master_model_inst.send(f, -1);
  endtask

  // outputs compared at the falling edge, where they are settled
  always @(negedge core_clk)
  begin
    if (!sys_rst && wr.en)
      chk("wr", {wr.addr, wr.data}, wq.size() ? wq.pop_front() : 'x);
    if (!sys_rst && tx.valid && tx_ready)
      chk("tx", tx.data, tq.size() ? tq.pop_front() : 'x);
  end

  // hang guard well above the expected run length
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      end_of_test();
    end
  end

  initial
  begin
    logic [15:0] w[$];
    repeat (12) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    single(8'h05, 16'h000d, 16'h1770);
    chk("crc", {f[6], f[7]}, 16'h1799);
    mbh_master_model_inst.slow = 1'b1;
    single(8'h05, PAR_HI, 16'($random(seed)));
    single(8'h05, 16'h00c8, 16'h0001);
    single(8'h05, 16'h2000, 16'h0002);
    single(BCAST_ADDR, SYS_LO, 16'hbeef);
    loopback(16'h0000);
    loopback(16'hffff);
    repeat (3) loopback(16'($random(seed)));
    mbh_master_model_inst.slow = 1'b0;
    station_addr = 8'h19;
    many(8'h19, 16'h03ee, '{16'h0005, 16'h000a});
    chk("crc", {f[11], f[12]}, 16'h863d);
    chk("rcrc", rc, 16'h2261);
    repeat (125) w.push_back(16'($random(seed)));
    mbh_master_model_inst.slow = 1'b1;
    many(8'h19, PAR_LO, w);
    many(BCAST_ADDR, SYS_LO, '{16'h1234, 16'h5678});
    // dropped queries: no write, no reply expected
    f = {8'h33, FC_WRITE_ONE, 8'h00, 8'h01, 8'h12, 8'h34};
    seal();
    mbh_master_model_inst.send(f, -1);
    f[0] = 8'h19;
    f[7] ^= 8'h01;
    mbh_master_model_inst.send(f, -1);
    f = {8'h19, FC_WRITE_ONE, 8'h00, 8'h01, 8'h12, 8'h34};
    seal();
    mbh_master_model_inst.send(f, 3);
    f = {BCAST_ADDR, FC_DIAG, 8'h00, 8'h00, 8'h12, 8'h34};
    seal();
    mbh_master_model_inst.send(f, -1);
    f = {8'h19, FC_DIAG, 8'h00, 8'h01, 8'h12, 8'h34};
    seal();
    mbh_master_model_inst.send(f, -1);
    f = {8'h19, FC_WRITE_MANY, 8'h03, 8'he7, 8'h00, 8'h7e, 8'hfc};
    repeat (252) f.push_back(8'h5a);
    seal();
    mbh_master_model_inst.send(f, -1);
    f = {8'h19, FC_WRITE_MANY, 8'h03, 8'he7, 8'h00, 8'h02, 8'h06};
    repeat (6) f.push_back(8'ha5);
    seal();
    mbh_master_model_inst.send(f, -1);
    f = {8'h19, FC_WRITE_ONE, 8'h00};
    mbh_master_model_inst.send(f, -1);
    repeat (20) @(posedge core_clk);
    chk("left", wq.size() + tq.size(), 0);
    end_of_test();
  end
endmodule

`default_nettype wire

//--- verilog/mbh_crc16.sv
// one-byte step of the frame check sequence, purely combinational
// assumes the caller holds the running value in its own register
`timescale 1ns/1ns
`default_nettype none

module mbh_crc16
  import mbh_pkg::*;
(
  input  wire logic [15:0] crc_in,   // running value before this byte
  input  wire logic [7:0]  data,     // byte entering the check
  output logic      [15:0] crc_out   // running value after this byte
);

  // ----------------------------------------------------------------------
  // eight shift steps, lsb first
  // ----------------------------------------------------------------------
  always_comb
  begin
    crc_out = crc_in ^ {8'h00, data};
    for (int b = 0; b < 8; b++)
    begin
      if (crc_out[0])
        crc_out = (crc_out >> 1) ^ CRC_POLY;
      else
        crc_out = crc_out >> 1;
    end
  end

endmodule

`default_nettype wire

//--- verilog/mbh_handler.sv
// slave-side handler for single write, loop-back and multiple write
// queries; assumes bytes arrive already deframed, with last marking the
// end-of-frame gap and err flagging parity, framing or overrun trouble
//
// How it works
// - function 06 writes one two-byte value
// - address field is register number minus 40001
// - address 0 broadcast accepted for writes
// - never reply to a broadcast query
// - single write reply echoes query bytes exactly
// - diagnostic subfunction 0000 echoes query unchanged
// - loop-back data is any two bytes, unchecked
// - multiple write names at most 125 registers
// - byte count equals twice count, 02..fa
// - multiple write reply: header fields plus crc
// - single write reaches only writable areas
// - crc trails frame, low byte first
// - errored queries are dropped without reply
`timescale 1ns/1ns
`default_nettype none

module mbh_handler
  import mbh_pkg::*;
#(
  parameter logic [15:0] SYS_WIN_LO = SYS_LO, // system variable window
  parameter logic [15:0] SYS_WIN_HI = SYS_HI,
  parameter logic [15:0] PAR_WIN_LO = PAR_LO, // drive parameter window
  parameter logic [15:0] PAR_WIN_HI = PAR_HI
)
(
  input  wire logic       core_clk,     // system clock, 250 MHz
  input  wire logic       sys_rst,      // async reset, high
  input  wire logic [7:0] station_addr, // own station address
  input  wire mbh_rx_type rx,           // received byte stream
  input  wire logic       tx_ready,     // reply sink takes byte
  output mbh_tx_type      tx,           // reply byte stream
  output mbh_wr_type      wr,           // holding register write
  output logic            busy          // query being processed
);

  // ----------------------------------------------------------------------
  // states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RECV  = 3'b000,
    ST_CHECK = 3'b001,
    ST_WRITE = 3'b010,
    ST_SEND  = 3'b011,
    ST_DRAIN = 3'b100
  } mbh_state_type;

  mbh_state_type state_reg;
  mbh_state_type state_next;

  // ----------------------------------------------------------------------
  // receive side storage
  // ----------------------------------------------------------------------
  logic [7:0]  hdr_reg [0:HDR_BYTES-1];
  logic [7:0]  data_mem [0:2*MAX_REGS-1];
  logic [8:0]  len_reg;
  logic        err_reg;
  logic [15:0] crc_reg;
  logic [15:0] crc_next;
  logic [8:0]  data_idx;

  // ----------------------------------------------------------------------
  // decision and write sequencing
  // ----------------------------------------------------------------------
  logic        bcast_reg;
  logic        many_reg;
  logic [6:0]  wr_idx_reg;
  logic [6:0]  wr_last_reg;
  logic        tx_load_reg;
  logic        tx_busy;

  // ----------------------------------------------------------------------
  // field views of the stored header, high byte first
  // ----------------------------------------------------------------------
  logic [7:0]  fc;
  logic [15:0] addr_field;
  logic [15:0] word_field;
  logic [7:0]  bc_field;
  logic        is_bcast;
  logic        is_mine;
  logic        frame_ok;
  logic        one_ok;
  logic        diag_ok;
  logic        many_ok;
  logic [15:0] wr_addr_next;
  logic [15:0] wr_data_next;
  logic [63:0] echo_frame;

  assign fc         = hdr_reg[1];
  assign addr_field = {hdr_reg[2], hdr_reg[3]};
  assign word_field = {hdr_reg[4], hdr_reg[5]};
  assign bc_field   = hdr_reg[6];
  assign data_idx   = len_reg - MANY_HDR_LEN;

  mbh_crc16 u_rx_crc
  (
    .crc_in  (crc_reg),
    .data    (rx.data),
    .crc_out (crc_next)
  );

  // ----------------------------------------------------------------------
  // writable area test; monitor and fault history fall outside both
  // ----------------------------------------------------------------------
  function automatic logic writable(input logic [15:0] a);
    writable = (a >= SYS_WIN_LO && a <= SYS_WIN_HI) ||
               (a >= PAR_WIN_LO && a <= PAR_WIN_HI);
  endfunction

  // ----------------------------------------------------------------------
  // byte intake; only taken while idle, so bytes arriving mid-processing
  // are lost and the broken remainder later fails its crc
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      len_reg <= 9'h000;
      err_reg <= 1'b0;
      crc_reg <= CRC_INIT;
    end
    else if (state_reg != ST_RECV)
    begin
      len_reg <= 9'h000;
      err_reg <= 1'b0;
      crc_reg <= CRC_INIT;
    end
    else if (rx.valid)
    begin
      if (len_reg != LEN_SAT)
        len_reg <= len_reg + 9'h001;
      err_reg <= err_reg | rx.err;
      crc_reg <= crc_next;
    end
  end

  // ----------------------------------------------------------------------
  // header bytes kept for the echo and the field decode
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < HDR_BYTES; i++)
        hdr_reg[i] <= 8'h00;
    end
    else if (state_reg == ST_RECV && rx.valid && len_reg < 9'(HDR_BYTES))
      hdr_reg[len_reg[2:0]] <= rx.data;
  end

  // ----------------------------------------------------------------------
  // multiple write data held whole; nothing may be written before the
  // crc has been seen, which costs a 250 byte store
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (state_reg == ST_RECV && rx.valid && fc == FC_WRITE_MANY &&
        len_reg >= MANY_HDR_LEN && data_idx < 9'(2 * MAX_REGS))
      data_mem[data_idx[7:0]] <= rx.data;
  end

  // ----------------------------------------------------------------------
  // query acceptance
  // ----------------------------------------------------------------------
  always_comb
  begin
    is_bcast = hdr_reg[0] == BCAST_ADDR;
    is_mine  = hdr_reg[0] == station_addr;
    frame_ok = !err_reg && crc_reg == CRC_GOOD &&
               len_reg >= MIN_LEN &&
               (is_mine || is_bcast);
    one_ok   = fc == FC_WRITE_ONE && len_reg == FIXED_LEN;
    diag_ok  = fc == FC_DIAG && len_reg == FIXED_LEN &&
               addr_field == DIAG_ECHO_SUB &&
               !is_bcast;
    many_ok  = fc == FC_WRITE_MANY &&
               word_field != 16'h0000 &&
               word_field <= MAX_REGS_W &&
               {8'h00, bc_field} == {word_field[14:0], 1'b0} &&
               bc_field >= BC_MIN && bc_field <= BC_MAX &&
               len_reg == MANY_OVERHEAD + {1'b0, bc_field};
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_RECV:
        if (rx.valid && rx.last)
          state_next = ST_CHECK;
      ST_CHECK:
        if (frame_ok && (one_ok || many_ok))
          state_next = ST_WRITE;
        else if (frame_ok && diag_ok)
          state_next = ST_SEND;
        else
          state_next = ST_RECV;
      ST_WRITE:
        if (wr_idx_reg == wr_last_reg)
          state_next = bcast_reg ? ST_RECV : ST_SEND;
      ST_SEND:
        state_next = ST_DRAIN;
      ST_DRAIN:
        if (!tx_busy)
          state_next = ST_RECV;
      default:
        state_next = ST_RECV;
    endcase
  end

  // ----------------------------------------------------------------------
  // state and busy flag; busy tells the master side when the processing
  // time of a silent broadcast is over
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg <= ST_RECV;
      busy      <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      busy      <= state_next != ST_RECV;
    end
  end

  // ----------------------------------------------------------------------
  // decision latch, taken in the check cycle
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bcast_reg   <= 1'b0;
      many_reg    <= 1'b0;
      wr_last_reg <= 7'h00;
    end
    else if (state_reg == ST_CHECK)
    begin
      bcast_reg   <= is_bcast;
      many_reg    <= fc == FC_WRITE_MANY;
      wr_last_reg <= (fc == FC_WRITE_MANY) ?
                     word_field[6:0] - 7'h01 : 7'h00;
    end
  end

  // ----------------------------------------------------------------------
  // write index walks the registers in ascending order
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      wr_idx_reg <= 7'h00;
    else if (state_reg == ST_WRITE)
      wr_idx_reg <= wr_idx_reg + 7'h01;
    else
      wr_idx_reg <= 7'h00;
  end

  // ----------------------------------------------------------------------
  // write data: the field value is the register offset, register number
  // being offset plus 40001, so the map needs no subtraction
  // ----------------------------------------------------------------------
  always_comb
  begin
    wr_addr_next = addr_field + {9'h000, wr_idx_reg};
    if (many_reg)
      wr_data_next = {data_mem[{wr_idx_reg, 1'b0}],
                      data_mem[{wr_idx_reg, 1'b1}]};
    else
      wr_data_next = word_field;
  end

  // ----------------------------------------------------------------------
  // write strobe; words outside the writable windows are dropped quietly
  // so one bad register does not spoil a block write
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      wr <= '0;
    else
    begin
      wr.en   <= state_reg == ST_WRITE && writable(wr_addr_next);
      wr.addr <= wr_addr_next;
      wr.data <= wr_data_next;
    end
  end

  // ----------------------------------------------------------------------
  // reply: echo of the stored query, or header plus fresh crc
  // ----------------------------------------------------------------------
  assign echo_frame = {hdr_reg[0], hdr_reg[1], hdr_reg[2], hdr_reg[3],
                       hdr_reg[4], hdr_reg[5], hdr_reg[6], hdr_reg[7]};

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      tx_load_reg <= 1'b0;
    else
      tx_load_reg <= state_next == ST_SEND;
  end

  mbh_tx u_tx
  (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .load     (tx_load_reg),
    .gen_crc  (many_reg),
    .frame    (echo_frame),
    .tx_ready (tx_ready),
    .tx       (tx),
    .busy     (tx_busy)
  );

endmodule

`default_nettype wire

//--- verilog/mbh_pkg.sv
// shared constants and carrier types for the serial write and loop-back
// handler; assumes byte-wide frames already stripped of character framing
`default_nettype none

package mbh_pkg;

  // ----------------------------------------------------------------------
  // function codes and fixed field values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  FC_WRITE_ONE  = 8'h06;
  localparam logic [7:0]  FC_DIAG       = 8'h08;
  localparam logic [7:0]  FC_WRITE_MANY = 8'h10;
  localparam logic [15:0] DIAG_ECHO_SUB = 16'h0000;
  localparam logic [7:0]  BCAST_ADDR    = 8'h00;

  // ----------------------------------------------------------------------
  // frame geometry
  // ----------------------------------------------------------------------
  localparam int          MAX_REGS      = 125;
  localparam logic [15:0] MAX_REGS_W    = 16'h007d;
  localparam logic [7:0]  BC_MIN        = 8'h02;
  localparam logic [7:0]  BC_MAX        = 8'hfa;
  localparam logic [8:0]  FIXED_LEN     = 9'h008;
  localparam logic [8:0]  MANY_HDR_LEN  = 9'h007;
  localparam logic [8:0]  MANY_OVERHEAD = 9'h009;
  localparam logic [8:0]  MIN_LEN       = 9'h004;
  localparam logic [8:0]  LEN_SAT       = 9'h1ff;
  localparam int          HDR_BYTES     = 8;
  localparam int          ECHO_CRC_IDX  = 6;

  // ----------------------------------------------------------------------
  // crc-16 with reflected polynomial; a good frame leaves zero behind
  // ----------------------------------------------------------------------
  localparam logic [15:0] CRC_INIT      = 16'hffff;
  localparam logic [15:0] CRC_POLY      = 16'ha001;
  localparam logic [15:0] CRC_GOOD      = 16'h0000;

  // ----------------------------------------------------------------------
  // writable holding register windows (field values, base 40001)
  // ----------------------------------------------------------------------
  localparam logic [15:0] SYS_LO        = 16'h0000;
  localparam logic [15:0] SYS_HI        = 16'h00c7;
  localparam logic [15:0] PAR_LO        = 16'h03e7;
  localparam logic [15:0] PAR_HI        = 16'h1fff;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic       last;
    logic       err;
    logic [7:0] data;
  } mbh_rx_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } mbh_tx_type;

  typedef struct packed {
    logic        en;
    logic [15:0] addr;
    logic [15:0] data;
  } mbh_wr_type;

endpackage

`default_nettype wire

//--- verilog/mbh_tx.sv
// reply sender: shifts out an eight byte frame with ready back-pressure
// assumes load only while idle; gen_crc replaces the last two bytes
`timescale 1ns/1ns
`default_nettype none

module mbh_tx
  import mbh_pkg::*;
(
  input  wire logic       core_clk,  // system clock
  input  wire logic       sys_rst,   // async reset, high
  input  wire logic       load,      // take frame, one cycle
  input  wire logic       gen_crc,   // compute crc over bytes 0..5
  input  wire logic [63:0] frame,    // byte 0 in the top lane
  input  wire logic       tx_ready,  // sink takes current byte
  output mbh_tx_type      tx,        // byte out, held until taken
  output logic            busy       // frame in flight
);

  logic [63:0] sh_reg;
  logic [3:0]  idx_reg;
  logic        gen_reg;
  logic [15:0] crc_reg;
  logic [15:0] crc_next;
  logic [7:0]  byte_next;

  mbh_crc16 u_crc
  (
    .crc_in  (crc_reg),
    .data    (sh_reg[63:56]),
    .crc_out (crc_next)
  );

  // ----------------------------------------------------------------------
  // byte selection: crc goes low byte first, then high byte
  // ----------------------------------------------------------------------
  always_comb
  begin
    byte_next = sh_reg[63:56];
    if (gen_reg && idx_reg == 4'(ECHO_CRC_IDX))
      byte_next = crc_reg[7:0];
    else if (gen_reg && idx_reg == 4'(ECHO_CRC_IDX + 1))
      byte_next = crc_reg[15:8];
  end

  // ----------------------------------------------------------------------
  // shifter; a byte moves only when the slot is empty or being taken
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sh_reg   <= 64'h0;
      idx_reg  <= 4'h0;
      gen_reg  <= 1'b0;
      crc_reg  <= CRC_INIT;
      busy     <= 1'b0;
      tx       <= '0;
    end
    else if (!busy)
    begin
      if (load)
      begin
        sh_reg  <= frame;
        idx_reg <= 4'h0;
        gen_reg <= gen_crc;
        crc_reg <= CRC_INIT;
        busy    <= 1'b1;
      end
    end
    else if (!tx.valid || tx_ready)
    begin
      if (idx_reg == 4'(HDR_BYTES))
      begin
        tx.valid <= 1'b0;
        busy     <= 1'b0;
      end
      else
      begin
        tx.valid <= 1'b1;
        tx.data  <= byte_next;
        sh_reg   <= {sh_reg[55:0], 8'h00};
        idx_reg  <= idx_reg + 4'h1;
        if (idx_reg < 4'(ECHO_CRC_IDX))
          crc_reg <= crc_next;
      end
    end
  end

endmodule

`default_nettype wire
